// *** hw/mspc_top.sv ***
`timescale 1ns/10ps
// Behaviour
// - a 4-bit delay field selects no delay (off-time sampling) or 1..15 steps of 2.5 us.
// - delay steps are counted in peripheral-clock cycles, 10 per step at 4 MHz.
// - an on-time sample that lands in the next off-time is discarded and sets pending bit 3.
// - the interrupt is raised only while mask bit 2 and the pending flag are both one.
// - only Z event sampling can produce the sampling-out condition, never D sampling.
// - with delay code zero no sampling-out event occurs.
// - a 2-bit input-frequency field selects the motor clock, code 00 is the peripheral clock.
// - the sampling config register resets to 02h.
// - parity bits are preloaded and applied at a C event, or at a phase-state write in direct mode.
// - the tacho edge field picks position/sensorless or rising, falling or both edge capture.
// - each of six parity bits drives its channel high for 0 and low for 1.
// - parity bits are ignored while the independent-phase config bit is one.
module mspc_top (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // sampling events from pins
   input wire logic i_periph_tick,
   input wire logic i_sample_z_req,
   input wire logic i_sample_d_req,
   input wire logic i_pwm_on,
   input wire logic i_c_event,
   input wire logic i_tacho_in,
   // outputs
   output logic o_irq,
   output logic [5:0] o_channel_level,
   output logic o_z_sample_valid,
   output logic o_d_sample_valid,
   output logic o_tacho_capture,
   output logic o_speed_mode,
   output logic [1:0] o_input_freq_select,
   output logic o_clk_is_periph
);
   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   logic [5:0] pins_s;
   mspc_sync2 #(.W(6)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_d({i_periph_tick, i_sample_z_req, i_sample_d_req, i_pwm_on, i_c_event, i_tacho_in}),
      .o_q(pins_s)
   );
   wire tick_s = pins_s[5];
   wire zreq_s = pins_s[4];
   wire dreq_s = pins_s[3];
   wire pwm_on_s = pins_s[2];
   wire c_s = pins_s[1];
   wire tacho_s = pins_s[0];

   logic zreq_d_r, dreq_d_r, c_d_r, tacho_d_r;
   wire z_req = zreq_s && !zreq_d_r;
   wire d_req = dreq_s && !dreq_d_r;
   wire c_evt = c_s && !c_d_r;
   wire t_rise = tacho_s && !tacho_d_r;
   wire t_fall = !tacho_s && tacho_d_r;

   // ----------------------------------------
   // registers and decode
   // ----------------------------------------
   mspc_pkg::mspc_bus_t bus;
   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] par_pre_r, par_act_r, phase_r;
   logic [2:0] ctrl_r;
   wire wr_cfg = bus.wr && bus.addr == mspc_pkg::ADDR_SAMPLING_CONFIG;
   wire wr_par = bus.wr && bus.addr == mspc_pkg::ADDR_PARITY_TACHO;
   wire wr_phase = bus.wr && bus.addr == mspc_pkg::ADDR_PHASE_STATE;
   wire wr_ctrl = bus.wr && bus.addr == mspc_pkg::ADDR_CTRL;
   wire wr_stat = bus.wr && bus.addr == mspc_pkg::ADDR_IRQ_STATUS;
   wire wr_mask = bus.wr && bus.addr == mspc_pkg::ADDR_IRQ_MASK;

   wire [3:0] delay_code = cfg_r[mspc_pkg::DELAY_LSB +: 4];
   wire pending = cfg_r[mspc_pkg::PENDING_BIT];
   wire mask = cfg_r[mspc_pkg::MASK_BIT];
   wire direct_mode = ctrl_r[mspc_pkg::CTRL_DIRECT_BIT];
   wire indep_phase = ctrl_r[mspc_pkg::CTRL_PCN_BIT];
   wire mspc_pkg::mspc_tacho_t tacho_mode =
      mspc_pkg::mspc_tacho_t'(par_act_r[mspc_pkg::TACHO_LSB +: 2]);

   // ----------------------------------------
   // on-time delayed z sampling
   // ----------------------------------------
   logic dly_busy, dly_done;
   mspc_delay_timer u_delay (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_tick(tick_s),
      .i_start(z_req),
      .i_steps(delay_code),
      .o_busy(dly_busy),
      .o_done(dly_done)
   );
   // the delayed sample is only good if on-time still holds when it lands
   wire z_late = dly_done && !pwm_on_s && delay_code != 4'h0;
   wire z_ok_delayed = dly_done && pwm_on_s;
   wire z_ok_direct = z_req && delay_code == 4'h0;

   // set beats software clear in the same cycle; the status and mask aliases
   // write through here too, so irq and the register never disagree
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = bus.wdata;
         cfg_nxt[mspc_pkg::PENDING_BIT] = pending & bus.wdata[mspc_pkg::PENDING_BIT];
      end
      if (wr_stat && bus.wdata[0]) begin
         cfg_nxt[mspc_pkg::PENDING_BIT] = 1'b0;
      end
      if (wr_mask) begin
         cfg_nxt[mspc_pkg::MASK_BIT] = bus.wdata[0];
      end
      if (z_late) begin
         cfg_nxt[mspc_pkg::PENDING_BIT] = 1'b1;
      end
   end

   // parity preload applied on c event or direct phase write
   wire par_load = direct_mode ? wr_phase : c_evt;
   wire [7:0] par_act_nxt = wr_par ? bus.wdata : par_pre_r;

   // read mux; unmapped addresses read zero
   wire [7:0] rd_mux =
      (bus.addr == mspc_pkg::ADDR_SAMPLING_CONFIG) ? cfg_r :
      (bus.addr == mspc_pkg::ADDR_PARITY_TACHO) ? par_pre_r :
      (bus.addr == mspc_pkg::ADDR_PHASE_STATE) ? phase_r :
      (bus.addr == mspc_pkg::ADDR_CTRL) ? {5'h00, ctrl_r} :
      (bus.addr == mspc_pkg::ADDR_IRQ_STATUS) ? {7'h00, pending} :
      (bus.addr == mspc_pkg::ADDR_IRQ_MASK) ? {7'h00, mask} : 8'h00;

   wire [5:0] par_eff = indep_phase ? 6'h00 : par_act_r[5:0];
   wire cap_hit = (tacho_mode == mspc_pkg::TACHO_RISE && t_rise) ||
                  (tacho_mode == mspc_pkg::TACHO_FALL && t_fall) ||
                  (tacho_mode == mspc_pkg::TACHO_BOTH && (t_rise || t_fall));

   // ----------------------------------------
   // state
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= mspc_pkg::SAMPLING_CONFIG_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // the preload image is what software reads back
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         par_pre_r <= mspc_pkg::PARITY_TACHO_RST;
      end else if (wr_par) begin
         par_pre_r <= bus.wdata;
      end
   end

   // the applied copy drives the channels and the tacho mode
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         par_act_r <= mspc_pkg::PARITY_TACHO_RST;
      end else if (par_load) begin
         par_act_r <= par_act_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_r <= mspc_pkg::PHASE_STATE_RST;
      end else if (wr_phase) begin
         phase_r <= bus.wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= 3'h0;
      end else if (wr_ctrl) begin
         ctrl_r <= bus.wdata[2:0];
      end
   end

   // edge registers idle low like their pins, so no false edge after reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         zreq_d_r <= 1'b0;
         dreq_d_r <= 1'b0;
         c_d_r <= 1'b0;
         tacho_d_r <= 1'b0;
      end else begin
         zreq_d_r <= zreq_s;
         dreq_d_r <= dreq_s;
         c_d_r <= c_s;
         tacho_d_r <= tacho_s;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   // irq and the frequency outputs follow the next config value, so they
   // move in the same cycle as the register and never lag an alias write
   wire [7:0] rdata_nxt = bus.rd ? rd_mux : 8'h00;
   wire irq_nxt = cfg_nxt[mspc_pkg::PENDING_BIT] & cfg_nxt[mspc_pkg::MASK_BIT];
   wire [1:0] freq_nxt = cfg_nxt[1:0];
   wire z_valid_nxt = z_ok_delayed || z_ok_direct;
   wire speed_nxt = tacho_mode != mspc_pkg::TACHO_POSITION;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_channel_level <= ~mspc_pkg::PARITY_TACHO_RST[5:0];
      end else begin
         o_channel_level <= ~par_eff;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_z_sample_valid <= 1'b0;
      end else begin
         o_z_sample_valid <= z_valid_nxt;
      end
   end

   // d sampling runs at the high sampling rate, never delayed
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_d_sample_valid <= 1'b0;
      end else begin
         o_d_sample_valid <= d_req;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tacho_capture <= 1'b0;
      end else begin
         o_tacho_capture <= cap_hit;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_speed_mode <= 1'b0;
      end else begin
         o_speed_mode <= speed_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_input_freq_select <= mspc_pkg::SAMPLING_CONFIG_RST[1:0];
         o_clk_is_periph <= 1'b0;
      end else begin
         o_input_freq_select <= freq_nxt;
         o_clk_is_periph <= freq_nxt == mspc_pkg::FREQ_PERIPH;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_irq_gating: assert property (o_irq == (pending && mask))
      else $error("irq does not follow pending and mask");
   a_late_sets: assert property (z_late |=> pending)
      else $error("late sample did not set pending");
   a_late_discard: assert property (z_late |=> !o_z_sample_valid)
      else $error("late sample not discarded");
   a_zero_no_event: assert property (delay_code == 4'h0 |-> !z_late)
      else $error("sampling out with zero delay");
   a_d_no_pending: assert property (d_req && !z_late && !pending && !wr_cfg |=> !pending)
      else $error("d sample set pending");
   a_parity_level: assert property (!indep_phase |=> o_channel_level == ~$past(par_act_r[5:0]))
      else $error("channel level mismatch");
   a_pcn_ignore: assert property (indep_phase |=> o_channel_level == 6'h3f)
      else $error("parity used with pcn");
   a_preload_hold: assert property (wr_par && !par_load |=> par_act_r == $past(par_act_r))
      else $error("preload applied early");
   a_freq_out: assert property (##1 o_input_freq_select == $past(cfg_nxt[1:0]))
      else $error("freq select mismatch");
   a_direct_sample: assert property (z_req && delay_code == 4'h0 |=> o_z_sample_valid)
      else $error("zero delay sample not taken");
   a_d_sample: assert property (d_req |=> o_d_sample_valid)
      else $error("d sample not taken");

   c_late: cover property (z_late);
   c_irq: cover property (o_irq);
   c_capture: cover property (o_tacho_capture);
   c_direct_load: cover property (direct_mode && wr_phase);
   c_timer_run: cover property (dly_busy && pwm_on_s);
endmodule

// *** hw/mspc_pkg.sv ***
package mspc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_SAMPLING_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_PARITY_TACHO = 4'h1;
   localparam logic [3:0] ADDR_PHASE_STATE = 4'h2;
   localparam logic [3:0] ADDR_CTRL = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
   localparam logic [7:0] SAMPLING_CONFIG_RST = 8'h02;
   localparam logic [7:0] PARITY_TACHO_RST = 8'h00;
   localparam logic [7:0] PHASE_STATE_RST = 8'h00;
   localparam int DELAY_LSB = 4;
   localparam int PENDING_BIT = 3;
   localparam int MASK_BIT = 2;
   localparam int TACHO_LSB = 6;
   localparam int CTRL_DIRECT_BIT = 0;
   localparam int CTRL_PCN_BIT = 1;
   localparam int CTRL_SZ_BIT = 2;
   // ----------------------------------------
   // timing: one delay step
   // ----------------------------------------
   localparam int STEP_NS = 2500;
   localparam int PERIPH_CLK_MHZ = 4;
   localparam int SYS_CLK_MHZ = 40;
   localparam int STEP_PERIPH_CYC = STEP_NS * PERIPH_CLK_MHZ / 1000;
   localparam logic [1:0] FREQ_PERIPH = 2'h0;

   typedef enum logic [1:0] {
      TACHO_POSITION = 2'b00,
      TACHO_RISE = 2'b01,
      TACHO_FALL = 2'b10,
      TACHO_BOTH = 2'b11
   } mspc_tacho_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mspc_bus_t;
endpackage

// *** hw/mspc_delay_timer.sv ***
`timescale 1ns/10ps
// counts delay steps of peripheral-clock ticks after a sample request
module mspc_delay_timer (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic i_start,
   input wire logic [3:0] i_steps,
   output logic o_busy,
   output logic o_done
);
   logic [5:0] tick_cnt_r;
   logic [3:0] step_cnt_r;
   wire step_end = i_tick && (tick_cnt_r == 6'(mspc_pkg::STEP_PERIPH_CYC - 1));
   wire last = step_end && (step_cnt_r == 4'h1);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt_r <= 6'h00;
         step_cnt_r <= 4'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= last;
         if (i_start && i_steps != 4'h0) begin
            o_busy <= 1'b1;
            step_cnt_r <= i_steps;
            tick_cnt_r <= 6'h00;
         end else if (o_busy) begin
            if (last) begin
               o_busy <= 1'b0;
            end
            if (step_end) begin
               tick_cnt_r <= 6'h00;
               step_cnt_r <= step_cnt_r - 4'h1;
            end else if (i_tick) begin
               tick_cnt_r <= tick_cnt_r + 6'h01;
            end
         end
      end
   end
endmodule

// *** hw/mspc_sync2.sv ***
`timescale 1ns/10ps
// two-flop synchroniser for pin levels
module mspc_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule

// *** testbench/mspc_partner.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// inverter and sensor pins
// ----------------------------------------
module mspc_partner (
   // clock
   input wire logic i_clk_sys,
   // pins toward the block: 0 z, 1 d, 2 c event, 3 tacho
   output logic o_periph_tick,
   output logic [3:0] o_pins,
   output logic o_pwm_on
);
   logic [3:0] div_r = 4'h0;
   initial begin
      o_pins = 4'h0;
      o_pwm_on = 1'b0;
   end
   // the peripheral clock runs free: one tick in ten system cycles
   always @(posedge i_clk_sys) begin
      div_r <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
   end
   assign o_periph_tick = (div_r == 4'h0);
   // held four cycles so the two-flop synchroniser cannot miss an edge
   task pulse(input int b);
      @(posedge i_clk_sys);
      o_pins <= o_pins | (4'h1 << b);
      repeat (4) @(posedge i_clk_sys);
      o_pins <= o_pins & ~(4'h1 << b);
      // six more edges let an event of the falling pin reach the counters
      repeat (6) @(posedge i_clk_sys);
   endtask
   task set_pwm(input logic v);
      @(posedge i_clk_sys);
      o_pwm_on <= v;
   endtask
endmodule

// *** testbench/mspc_top_test.sv ***
`timescale 1ns/10ps
module mspc_top_test;
   logic clk;
   logic rst_n;
   logic wr;
   logic rd;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic tick, pwm, irq, zv, dv, cap, spd, isp;
   logic [3:0] pins;
   wire z_pin, d_pin, c_pin, t_pin;
   assign {t_pin, c_pin, d_pin, z_pin} = pins;
   logic [5:0] lvl;
   logic [5:0] par;
   logic [1:0] fsel;
   logic [7:0] pre = 8'h3f;
   int failures = 0;
   int n_checks = 0;
   int nz = 0;
   int nd = 0;
   int ncap = 0;
   int n0;
   always #12.5 clk = ~clk;
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
   end
   always @(posedge clk) begin
      if (zv === 1'b1) nz <= nz + 1;
      if (dv === 1'b1) nd <= nd + 1;
      if (cap === 1'b1) ncap <= ncap + 1;
   end
   mspc_top u_mspc_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_periph_tick(tick), .i_sample_z_req(z_pin),
      .i_sample_d_req(d_pin), .i_pwm_on(pwm), .i_c_event(c_pin), .i_tacho_in(t_pin),
      .o_irq(irq), .o_channel_level(lvl), .o_z_sample_valid(zv), .o_d_sample_valid(dv),
      .o_tacho_capture(cap), .o_speed_mode(spd), .o_input_freq_select(fsel),
      .o_clk_is_periph(isp));
   mspc_partner u_mspc_partner (.i_clk_sys(clk), .o_periph_tick(tick), .o_pins(pins),
      .o_pwm_on(pwm));
   // ----------------------------------------
   // checking and register access
   // ----------------------------------------
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_irq;
      int k;
      for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
      if (irq !== 1'b1) begin
         failures++;
         results();
      end
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      results();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h02);
      rd_chk(mspc_pkg::ADDR_PARITY_TACHO, 8'h00);
      chk({6'h00, fsel}, 8'h02);
      chk({2'h0, lvl}, 8'h3f);
      rd_chk(4'hf, 8'h00);
      wr_reg(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h00);
      repeat (2) @(posedge clk);
      chk({5'h00, isp, fsel}, 8'h04);
      for (int m = 0; m < 4; m++) begin
         par = 6'h05 + 6'(m);
         wr_reg(mspc_pkg::ADDR_PARITY_TACHO, {2'(m), par});
         rd_chk(mspc_pkg::ADDR_PARITY_TACHO, {2'(m), par});
         chk({2'h0, lvl}, pre);
         u_mspc_partner.pulse(2);
         pre = {2'h0, ~par};
         chk({2'h0, lvl}, pre);
         chk({7'h00, spd}, {7'h00, m != 0});
         n0 = ncap;
         u_mspc_partner.pulse(3);
         chk(8'(ncap - n0), (m == 3) ? 8'h02 : {7'h00, m != 0});
      end
      wr_reg(mspc_pkg::ADDR_CTRL, 8'h01);
      wr_reg(mspc_pkg::ADDR_PARITY_TACHO, 8'h11);
      repeat (3) @(posedge clk);
      chk({2'h0, lvl}, pre);
      wr_reg(mspc_pkg::ADDR_PHASE_STATE, 8'h00);
      repeat (3) @(posedge clk);
      chk({2'h0, lvl}, 8'h2e);
      wr_reg(mspc_pkg::ADDR_CTRL, 8'h03);
      repeat (3) @(posedge clk);
      chk({2'h0, lvl}, 8'h3f);
      wr_reg(mspc_pkg::ADDR_CTRL, 8'h00);
      // one delay step, on-time ends before the step runs out
      wr_reg(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h14);
      u_mspc_partner.set_pwm(1'b1);
      n0 = nz;
      u_mspc_partner.pulse(0);
      u_mspc_partner.set_pwm(1'b0);
      wait_irq();
      chk(8'(nz - n0), 8'h00);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h1c);
      rd_chk(mspc_pkg::ADDR_IRQ_STATUS, 8'h01);
      wr_reg(mspc_pkg::ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h18);
      wr_reg(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h14);
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h14);
      u_mspc_partner.pulse(0);
      wait_irq();
      wr_reg(mspc_pkg::ADDR_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      // sample lands inside on-time: kept, no flag
      u_mspc_partner.set_pwm(1'b1);
      n0 = nz;
      u_mspc_partner.pulse(0);
      repeat (200) @(posedge clk);
      chk(8'(nz - n0), 8'h01);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h14);
      u_mspc_partner.set_pwm(1'b0);
      n0 = nd;
      u_mspc_partner.pulse(1);
      repeat (200) @(posedge clk);
      chk(8'(nd - n0), 8'h01);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h14);
      wr_reg(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h04);
      u_mspc_partner.pulse(0);
      repeat (50) @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      rd_chk(mspc_pkg::ADDR_SAMPLING_CONFIG, 8'h04);
      results();
   end
endmodule
